/* core/ddmas_regs.sv */
/*
 Distributed DMA slave register block: 16-byte I/O window with address,
 page, count and status/command registers, the transfer address/count
 update, and address-phase driving of the 24 address bits.
 Assumes byte-wide I/O accesses already qualified by the bus interface, and
 a transfer engine that pulses xfer_start_i and xfer_done_i.
*/
`include "ddmas_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddmas_regs
    import ddmas_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int PAGE_W = 8
)
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_ofs_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic wide_mode_i,
    input wire logic dreq_i,
    input wire logic xfer_start_i,
    input wire logic xfer_done_i,
    output logic [7:0] io_rdata_o,
    output logic io_hit_o,
    output logic [23:0] ad_o,
    output logic ad_valid_o,
    output logic enabled_o,
    output logic tc_o
);
    logic [15:0] win_base_q, win_base_d;
    logic [ADDR_W-1:0] base_addr_q, base_addr_d;
    logic [ADDR_W-1:0] cur_addr_q, cur_addr_d;
    logic [PAGE_W-1:0] page_q, page_d;
    logic [15:0] base_cnt_q, base_cnt_d;
    logic [15:0] cur_cnt_q, cur_cnt_d;
    logic en_q, en_d;
    logic tc_q, tc_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit_q, hit_d;
    logic adv_q, adv_d;
    ddmas_state_type state_q, state_d;
    logic [`DDMAS_WIN_BITS-1:0] ofs;
    logic in_win;
    logic rd_hit;
    logic wr_hit;
    logic [15:0] step;

    // Window compare; the low nibble selects a register inside it
    function automatic logic win_match(input logic [15:0] a, input logic [15:0] b);
        win_match = (a[15:`DDMAS_WIN_BITS] == b[15:`DDMAS_WIN_BITS]);
    endfunction

    assign in_win = win_match(io_addr_i, win_base_q);
    assign ofs = io_addr_i[`DDMAS_WIN_BITS-1:0];
    assign rd_hit = io_rd_i && in_win;
    assign wr_hit = io_wr_i && in_win;
    // Address and count move by the transfer width, so both share one step
    assign step = wide_mode_i ? `DDMAS_STEP16 : `DDMAS_STEP8;

    // Configuration side: window base
    always_comb
    begin
        win_base_d = win_base_q;
        if (cfg_wr_i && cfg_ofs_i == `DDMAS_CFG_BASE_OFS)
        begin
            win_base_d = {cfg_wdata_i[15:`DDMAS_WIN_BITS], {`DDMAS_WIN_BITS{1'b0}}};
        end
    end

    // Register writes; unlisted offsets and obsolete bits fall through untouched
    always_comb
    begin
        base_addr_d = base_addr_q;
        cur_addr_d = cur_addr_q;
        page_d = page_q;
        base_cnt_d = base_cnt_q;
        cur_cnt_d = cur_cnt_q;
        en_d = en_q;
        // A register byte write in the same cycle as a done wins over the step for that byte only
        if (xfer_done_i && en_q)
        begin
            cur_addr_d = cur_addr_q + ADDR_W'(step);
            cur_cnt_d = cur_cnt_q - step;
        end
        if (wr_hit)
        begin
            if (ofs == `DDMAS_OFS_ADDR_LO)
            begin
                base_addr_d[7:0] = io_wdata_i;
                cur_addr_d[7:0] = io_wdata_i;
            end
            else if (ofs == `DDMAS_OFS_ADDR_HI)
            begin
                base_addr_d[15:8] = io_wdata_i;
                cur_addr_d[15:8] = io_wdata_i;
            end
            else if (ofs == `DDMAS_OFS_PAGE)
            begin
                page_d = io_wdata_i;
            end
            else if (ofs == `DDMAS_OFS_CNT_LO)
            begin
                base_cnt_d[7:0] = io_wdata_i;
                cur_cnt_d[7:0] = io_wdata_i;
            end
            else if (ofs == `DDMAS_OFS_CNT_HI)
            begin
                base_cnt_d[15:8] = io_wdata_i;
                cur_cnt_d[15:8] = io_wdata_i;
            end
            else if (ofs == `DDMAS_OFS_STAT_CMD)
            begin
                // Only the disable bit (bit 2) is stored, inverted as the enable; the rest has no function
                en_d = !io_wdata_i[`DDMAS_CMD_DIS_BIT];
            end
            // Any other offset is reserved: no state changes
        end
    end

    // Terminal count flag: set wins over clear-on-read
    always_comb
    begin
        tc_d = tc_q;
        if (rd_hit && ofs == `DDMAS_OFS_STAT_CMD)
        begin
            tc_d = 1'b0;
        end
        if (xfer_done_i && en_q && cur_cnt_q <= step)
        begin
            tc_d = 1'b1;
        end
    end

    // Read path; legacy layout kept so forwarded writes need no translation
    always_comb
    begin
        rdata_d = `DDMAS_BYTE_ZERO;
        hit_d = rd_hit;
        if (rd_hit)
        begin
            if (ofs == `DDMAS_OFS_ADDR_LO)
            begin
                rdata_d = cur_addr_q[7:0];
            end
            else if (ofs == `DDMAS_OFS_ADDR_HI)
            begin
                rdata_d = cur_addr_q[15:8];
            end
            else if (ofs == `DDMAS_OFS_PAGE)
            begin
                rdata_d = page_q;
            end
            else if (ofs == `DDMAS_OFS_CNT_LO)
            begin
                rdata_d = cur_cnt_q[7:0];
            end
            else if (ofs == `DDMAS_OFS_CNT_HI)
            begin
                rdata_d = cur_cnt_q[15:8];
            end
            else if (ofs == `DDMAS_OFS_STAT_CMD)
            begin
                rdata_d = {{`DDMAS_STAT_REP{dreq_i}}, {`DDMAS_STAT_REP{tc_q}}};
            end
        end
    end

    // Address phase sequencing
    always_comb
    begin
        state_d = state_q;
        adv_d = 1'b0;
        case (state_q)
            DDMAS_IDLE_ST:
            begin
                if (xfer_start_i && en_q)
                begin
                    state_d = DDMAS_ADDR_ST;
                end
            end
            DDMAS_ADDR_ST:
            begin
                adv_d = 1'b1;
                state_d = DDMAS_DATA_ST;
            end
            DDMAS_DATA_ST:
            begin
                if (xfer_done_i)
                begin
                    state_d = DDMAS_IDLE_ST;
                end
            end
            default:
            begin
                state_d = DDMAS_IDLE_ST;
            end
        endcase
    end

    // Window base
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            win_base_q <= `DDMAS_WIN_RST;
        end
        else if (clk_en_i)
        begin
            win_base_q <= win_base_d;
        end
    end

    // Programmed registers; the enable is kept as a flop so the port needs no inverter
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            base_addr_q <= `DDMAS_ADDR_RST;
            cur_addr_q <= `DDMAS_ADDR_RST;
            page_q <= `DDMAS_PAGE_RST;
            base_cnt_q <= `DDMAS_CNT_RST;
            cur_cnt_q <= `DDMAS_CNT_RST;
            en_q <= `DDMAS_EN_RST;
        end
        else if (clk_en_i)
        begin
            base_addr_q <= base_addr_d;
            cur_addr_q <= cur_addr_d;
            page_q <= page_d;
            base_cnt_q <= base_cnt_d;
            cur_cnt_q <= cur_cnt_d;
            en_q <= en_d;
        end
    end

    // Terminal count flag
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tc_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            tc_q <= tc_d;
        end
    end

    // Read answer; a frozen clock also freezes the answer on the port
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q <= `DDMAS_BYTE_ZERO;
            hit_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    // Address phase sequencer
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            adv_q <= 1'b0;
            state_q <= DDMAS_IDLE_ST;
        end
        else if (clk_en_i)
        begin
            adv_q <= adv_d;
            state_q <= state_d;
        end
    end

    ddmas_addr_drive u_addr_drive
    (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .load_i(state_q == DDMAS_ADDR_ST),
        .wide_i(wide_mode_i),
        .cur_addr_i(cur_addr_q),
        .page_i(page_q),
        .ad_o(ad_o)
    );

    assign io_rdata_o = rdata_q;
    assign io_hit_o = hit_q;
    assign ad_valid_o = adv_q;
    assign enabled_o = en_q;
    assign tc_o = tc_q;
endmodule
`default_nettype wire

/* core/ddmas_defs.svh */
/*
 Constants for the distributed DMA slave register block: window offsets,
 field positions, reset values and sizes. Assumes inclusion by bare name.
*/
`ifndef DDMAS_DEFS_SVH
`define DDMAS_DEFS_SVH
`define DDMAS_CFG_BASE_OFS 8'h98
`define DDMAS_WIN_RST 16'h0000
`define DDMAS_EN_RST 1'b1
`define DDMAS_AD_RST 24'h000000
`define DDMAS_STAT_REP 4
`define DDMAS_WIN_BITS 4
`define DDMAS_OFS_ADDR_LO 4'h0
`define DDMAS_OFS_ADDR_HI 4'h1
`define DDMAS_OFS_PAGE 4'h2
`define DDMAS_OFS_CNT_LO 4'h4
`define DDMAS_OFS_CNT_HI 4'h5
`define DDMAS_OFS_STAT_CMD 4'h8
`define DDMAS_CMD_DIS_BIT 2
`define DDMAS_ADDR_RST 16'h0000
`define DDMAS_PAGE_RST 8'h00
`define DDMAS_CNT_RST 16'h0000
`define DDMAS_BYTE_ZERO 8'h00
`define DDMAS_STEP8 16'h0001
`define DDMAS_STEP16 16'h0002
`endif

/* core/ddmas_pkg.sv */
/*
 Types for the distributed DMA slave register block.
 Assumes the constants header is compiled alongside.
*/
package ddmas_pkg;
    typedef enum logic [1:0] {
        DDMAS_IDLE_ST = 2'b00,
        DDMAS_ADDR_ST = 2'b01,
        DDMAS_DATA_ST = 2'b10
    } ddmas_state_type;
endpackage

/* core/ddmas_addr_drive.sv */
/*
 Address-phase formatter: turns current address and page into the 24 address
 bits for 8-bit or 16-bit transfer mode, registered.
 Assumes the caller strobes load_i in the cycle before the address phase.
*/
`include "ddmas_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ddmas_addr_drive
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic load_i,
    input wire logic wide_i,
    input wire logic [15:0] cur_addr_i,
    input wire logic [7:0] page_i,
    output logic [23:0] ad_o
);
    logic [23:0] ad_q;
    logic [23:0] ad_d;

    always_comb
    begin
        ad_d = ad_q;
        if (load_i)
        begin
            if (wide_i)
            begin
                // Page bit 0 is dropped in wide mode
                ad_d = {page_i[7:1], cur_addr_i, 1'b0};
            end
            else
            begin
                ad_d = {page_i, cur_addr_i};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ad_q <= `DDMAS_AD_RST;
        end
        else if (clk_en_i)
        begin
            ad_q <= ad_d;
        end
    end

    assign ad_o = ad_q;
endmodule
`default_nettype wire

/* verif/ddmas_regs_monitor.sv */
/*
 Port checker for the register block: read answer, address phase, enable.
 Assumes clk_en_i drops only while no transfer or read answer is pending,
 and that starts are spaced by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ddmas_regs_monitor
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic io_rd_i,
    input wire logic xfer_start_i,
    input wire logic wide_mode_i,
    input wire logic io_hit_o,
    input wire logic ad_valid_o,
    input wire logic enabled_o,
    input wire logic [7:0] io_rdata_o,
    input wire logic [23:0] ad_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    chk_hit_cause: assert property (io_hit_o |-> $past(io_rd_i && clk_en_i))
        else $error("hit without read");
    chk_rdata_idle: assert property (!$past(io_rd_i) |-> io_rdata_o == 8'h00)
        else $error("read data not cleared");
    chk_ad_latency: assert property (ad_valid_o |-> $past(xfer_start_i, 2))
        else $error("address phase without start");
    chk_start_valid: assert property (xfer_start_i && enabled_o |-> ##2 ad_valid_o)
        else $error("start not answered");
    chk_dis_start: assert property (xfer_start_i && !enabled_o |-> ##2 !ad_valid_o)
        else $error("start taken while disabled");
    chk_valid_pulse: assert property (ad_valid_o |=> !ad_valid_o)
        else $error("valid longer than a cycle");
    chk_ad_stable: assert property (!ad_valid_o |-> $stable(ad_o))
        else $error("address moved outside phase");
    chk_wide_lsb: assert property (ad_valid_o && wide_mode_i |-> !ad_o[0])
        else $error("line 0 high in wide mode");
    cover property (ad_valid_o && wide_mode_i);
    cover property (ad_valid_o && !wide_mode_i);
    cover property (io_hit_o);
endmodule
bind ddmas_regs ddmas_regs_monitor u_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .io_rd_i(io_rd_i), .xfer_start_i(xfer_start_i), .wide_mode_i(wide_mode_i), .io_hit_o(io_hit_o),
    .ad_valid_o(ad_valid_o), .enabled_o(enabled_o), .io_rdata_o(io_rdata_o), .ad_o(ad_o));
`default_nettype wire

/* verif/ddmas_host_model.sv */
/*
 Host model: config writes, byte I/O cycles and transfer pulses.
 Assumes the bench calls its tasks; signals change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ddmas_host_model
(
    input wire logic mclk_i,
    input wire logic [7:0] io_rdata_i,
    output logic cfg_wr_o,
    output logic io_rd_o,
    output logic io_wr_o,
    output logic xfer_start_o,
    output logic xfer_done_o,
    output logic [7:0] cfg_ofs_o,
    output logic [7:0] io_wdata_o,
    output logic [15:0] cfg_wdata_o,
    output logic [15:0] io_addr_o
);
    initial
    begin
        {cfg_wr_o, io_rd_o, io_wr_o, xfer_start_o, xfer_done_o} = '0;
        {cfg_ofs_o, io_wdata_o, cfg_wdata_o, io_addr_o} = '0;
    end
    task automatic cfg(input logic [7:0] o, input logic [15:0] d);
        @(negedge mclk_i);
        cfg_wr_o = 1'b1;
        cfg_ofs_o = o;
        cfg_wdata_o = d;
        @(negedge mclk_i);
        cfg_wr_o = 1'b0;
        cfg_wdata_o = ~d;
    endtask
    // Byte cycles at legacy offsets, answer sampled one cycle on
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk_i);
        io_wr_o = w;
        io_rd_o = !w;
        io_addr_o = a;
        io_wdata_o = d;
        @(negedge mclk_i);
        q = io_rdata_i;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    task automatic pulse(input logic s);
        @(negedge mclk_i);
        xfer_start_o = s;
        xfer_done_o = !s;
        @(negedge mclk_i);
        xfer_start_o = 1'b0;
        xfer_done_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
/*
 Self-checking bench for the register block behind the host model.
 Assumes clk_en_i is dropped only between reads or across a whole write access; expectations come from
 bench functions.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, wide_mode_i = 1'b0, dreq_i = 1'b0, clk_en_i = 1'b1;
    logic cfg_wr_i, io_rd_i, io_wr_i, xfer_start_i, xfer_done_i, io_hit_o, ad_valid_o, enabled_o, tc_o;
    logic [7:0] cfg_ofs_i, io_wdata_i, io_rdata_o, q, p;
    logic [15:0] cfg_wdata_i, io_addr_i, a, b, c, e;
    logic [23:0] ad_o, h;
    int err_count = 0, tests_run = 0, seed = 3241;
    logic [3:0] rsv [5] = '{4'h3, 4'h6, 4'h7, 4'hC, 4'hE};
    initial forever #10 mclk_i = ~mclk_i;
    ddmas_regs DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .cfg_wr_i(cfg_wr_i),
        .cfg_ofs_i(cfg_ofs_i), .cfg_wdata_i(cfg_wdata_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .wide_mode_i(wide_mode_i), .dreq_i(dreq_i),
        .xfer_start_i(xfer_start_i), .xfer_done_i(xfer_done_i), .io_rdata_o(io_rdata_o),
        .io_hit_o(io_hit_o), .ad_o(ad_o), .ad_valid_o(ad_valid_o), .enabled_o(enabled_o), .tc_o(tc_o));
    ddmas_host_model host (.mclk_i(mclk_i), .io_rdata_i(io_rdata_o), .cfg_wr_o(cfg_wr_i), .io_rd_o(io_rd_i),
        .io_wr_o(io_wr_i), .xfer_start_o(xfer_start_i), .xfer_done_o(xfer_done_i), .cfg_ofs_o(cfg_ofs_i),
        .io_wdata_o(io_wdata_i), .cfg_wdata_o(cfg_wdata_i), .io_addr_o(io_addr_i));
    function automatic logic [23:0] exp_ad(input logic [15:0] ad, input logic [7:0] pg, input logic w);
        return w ? {pg[7:1], ad, 1'b0} : {pg, ad};
    endfunction
    task automatic chk(input string n, input logic [23:0] ev, input logic [23:0] sv);
        tests_run++;
        if (sv !== ev)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, ev, sv);
        end
    endtask
    task automatic wr(input logic [3:0] o, input logic [7:0] d);
        host.io(1'b1, b | 16'(o), d, q);
    endtask
    task automatic rc(input string n, input logic [3:0] o, input logic [7:0] ev);
        host.io(1'b0, b | 16'(o), 8'h00, q);
        chk("hit", 24'h1, 24'(io_hit_o));
        chk(n, 24'(ev), 24'(q));
    endtask
    task automatic results;
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        results();
    end
    initial
    begin
        repeat (8) @(negedge mclk_i);
        reset_n_i = 1'b1;
        b = 16'($random(seed)) & 16'hFFF0;
        host.cfg(8'h98, b);
        rc("addr_rst", 4'h1, 8'h00);
        rc("page_rst", 4'h2, 8'h00);
        foreach (rsv[k])
        begin
            wr(rsv[k], 8'($random(seed)));
            rc("reserved", rsv[k], 8'h00);
        end
        rc("addr_kept", 4'h0, 8'h00);
        // Let the read answer clear, then show that a frozen clock drops a page write
        @(negedge mclk_i);
        clk_en_i = 1'b0;
        wr(4'h2, 8'hA5);
        clk_en_i = 1'b1;
        rc("page_kept", 4'h2, 8'h00);
        host.io(1'b0, b ^ 16'h0010, 8'h00, q);
        chk("miss", 24'h0, 24'(io_hit_o));
        dreq_i = 1'($random(seed));
        wr(4'h8, 8'hFB);
        chk("enabled", 24'h1, 24'(enabled_o));
        rc("status", 4'h8, {{4{dreq_i}}, 4'h0});
        for (int i = 0; i < 4; i++)
        begin
            a = 16'($random(seed));
            p = 8'($random(seed));
            c = 16'($random(seed)) | 16'h0100;
            wide_mode_i = i[0];
            wr(4'h0, a[7:0]);
            wr(4'h1, a[15:8]);
            wr(4'h2, p);
            wr(4'h4, c[7:0]);
            wr(4'h5, c[15:8]);
            rc("base_lo", 4'h0, a[7:0]);
            rc("page", 4'h2, p);
            host.pulse(1'b1);
            repeat (2) @(negedge mclk_i);
            chk("ad", exp_ad(a, p, i[0]), ad_o);
            host.pulse(1'b0);
            e = a + 16'(1 + i[0]);
            rc("cur_lo", 4'h0, e[7:0]);
            rc("cur_hi", 4'h1, e[15:8]);
            e = c - 16'(1 + i[0]);
            rc("cnt_lo", 4'h4, e[7:0]);
        end
        wide_mode_i = 1'b0;
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h00);
        host.pulse(1'b1);
        host.pulse(1'b0);
        chk("tc_set", 24'h1, 24'(tc_o));
        rc("tc_status", 4'h8, {{4{dreq_i}}, 4'hF});
        chk("tc_clear", 24'h0, 24'(tc_o));
        rc("cnt_end", 4'h4, 8'h00);
        h = ad_o;
        wr(4'h8, 8'h04);
        chk("disabled", 24'h0, 24'(enabled_o));
        host.pulse(1'b1);
        repeat (3) @(negedge mclk_i);
        chk("ad_hold", h, ad_o);
        wr(4'h0, 8'h5A);
        host.pulse(1'b0);
        rc("dis_addr", 4'h0, 8'h5A);
        wr(4'h8, 8'h00);
        chk("reenabled", 24'h1, 24'(enabled_o));
        results();
    end
endmodule
`default_nettype wire
